// ==== hw/pwr_mon_regs.vh ====
// Register map, field positions, reset values and timing for the power monitor control.
// Assumes a 100 MHz core clock and a register port fed by an external serial slave.
`ifndef PWR_MON_REGS_VH
`define PWR_MON_REGS_VH

// Register offsets
`define OFS_CONFIG      8'h00
`define OFS_SHUNT       8'h01
`define OFS_BUS         8'h02
`define OFS_POWER       8'h03
`define OFS_CURRENT     8'h04
`define OFS_CALIB       8'h05
`define OFS_STATUS      8'h06

// Configuration fields
`define CFG_RESET       16'h399f
`define CFG_SWRST       15
`define CFG_BUS_RANGE   13
`define CFG_GAIN_MSB    12
`define CFG_GAIN_LSB    11
`define CFG_BAVG_MSB    10
`define CFG_BAVG_LSB    7
`define CFG_SAVG_MSB    6
`define CFG_SAVG_LSB    3
`define CFG_MODE_MSB    2
`define CFG_MODE_LSB    0

// Averaging field: top bit selects multi-sample, low bits give log2 of count
`define AVG_MULTI       3
`define AVG_LOG_MSB     2
`define AVG_RES_MSB     1

// Mode field encodings and bits
`define MODE_PDOWN      3'h0
`define MODE_ADC_OFF    3'h4
`define MODE_CONT_BOTH  3'h7
`define MODE_BIT_SHUNT  0
`define MODE_BIT_BUS    1
`define MODE_BIT_CONT   2

// Status fields
`define STAT_BUSY       0
`define STAT_READY      1

// Results
`define CAL_RESET       16'h0000
`define RES_RESET       16'h0000
`define BUS_ALIGN       3
`define CUR_SHIFT       12
`define PWR_DIVISOR     16'h1388

// Power-down recovery
`define CLK_PERIOD_NS   10
`define PD_RECOVERY_NS  40000
`define PD_RECOVERY_CYC ((`PD_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== hw/pwr_calc.v ====
// Background current and power computation from committed conversion results.
// Assumes operands stay stable from start until done; two-cycle latency.
`default_nettype none
`include "pwr_mon_regs.vh"

module pwr_calc (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        start,
  input  wire [15:0] shunt,
  input  wire [12:0] bus,
  input  wire [15:0] cal,
  output reg         done,
  output reg  [15:0] current,
  output reg  [15:0] power
);

  wire signed [32:0] prod_cur;
  wire        [15:0] cur_abs;
  wire        [28:0] prod_pwr;
  wire        [28:0] pwr_div;
  reg                stage_q;

  assign prod_cur = $signed(shunt) * $signed({1'b0, cal});
  assign cur_abs  = current[15] ? (~current + 16'h0001) : current;
  assign prod_pwr = cur_abs * bus;
  assign pwr_div  = prod_pwr / `PWR_DIVISOR;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_q <= 1'b0;
      done    <= 1'b0;
      current <= `RES_RESET;
      power   <= `RES_RESET;
    end else begin
      stage_q <= start;
      done    <= stage_q;
      if (start) begin
        // Zero calibration leaves both results at zero
        current <= (cal == `CAL_RESET) ? `RES_RESET :
                   prod_cur[`CUR_SHIFT+15:`CUR_SHIFT];
      end
      if (stage_q) begin
        power <= (cal == `CAL_RESET) ? `RES_RESET : pwr_div[15:0];
      end
    end
  end

endmodule
`default_nettype wire

// ==== hw/pwr_mon_ctrl.v ====
// Conversion sequencing, averaging, result registers and register port.
// Assumes an external serial slave presents reg_rd/reg_wr pulses and an external ADC
// answers each adc_start pulse with one adc_done pulse.
`default_nettype none
`include "pwr_mon_regs.vh"

module pwr_mon_ctrl (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata_q,
  input  wire        convert_start,
  output reg         adc_start_q,
  output reg         adc_chan_q,
  output reg  [1:0]  adc_res_q,
  input  wire        adc_done,
  input  wire [15:0] adc_data,
  output reg  [1:0]  shunt_gain_setting_q,
  output reg         bus_range_select_q,
  output reg         power_down_q
);

  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_WAKE  = 6'h02;
  localparam [5:0] S_SREQ  = 6'h04;
  localparam [5:0] S_SWAIT = 6'h08;
  localparam [5:0] S_BREQ  = 6'h10;
  localparam [5:0] S_BWAIT = 6'h20;

  localparam integer WAKE_CYC  = `PD_RECOVERY_CYC - 1;
  localparam [11:0]  WAKE_LAST = WAKE_CYC[11:0];

  reg  [15:0] cfg_q;
  reg  [15:0] cal_q;
  reg  [15:0] shunt_q;
  reg  [15:0] bus_q;
  reg  [15:0] shunt_new_q;
  reg         ready_q;
  reg  [5:0]  state_q;
  reg  [7:0]  cnt_q;
  reg  [11:0] wake_q;
  reg  signed [22:0] acc_q;
  reg         calc_start_q;

  wire [2:0]  mode;
  wire [2:0]  wmode;
  wire [3:0]  savg;
  wire [3:0]  bavg;
  wire [3:0]  cur_avg;
  wire [2:0]  avg_log;
  wire [7:0]  avg_last;
  wire signed [22:0] sample_ext;
  wire signed [22:0] acc_sum;
  wire signed [22:0] avg_val;
  wire        cfg_wr;
  wire        cal_wr;
  wire        stat_rd;
  wire        wr_active;
  wire        trig_mode;
  wire        pin_shot;
  wire        shot_go;
  wire        calc_done;
  wire [15:0] calc_cur;
  wire [15:0] calc_pwr;

  assign mode      = cfg_q[`CFG_MODE_MSB:`CFG_MODE_LSB];
  assign wmode     = reg_wdata[`CFG_MODE_MSB:`CFG_MODE_LSB];
  assign savg      = cfg_q[`CFG_SAVG_MSB:`CFG_SAVG_LSB];
  assign bavg      = cfg_q[`CFG_BAVG_MSB:`CFG_BAVG_LSB];
  assign cfg_wr    = reg_wr && (reg_addr == `OFS_CONFIG);
  assign cal_wr    = reg_wr && (reg_addr == `OFS_CALIB);
  assign stat_rd   = reg_rd && (reg_addr == `OFS_STATUS);
  assign wr_active = (wmode != `MODE_PDOWN) && (wmode != `MODE_ADC_OFF);
  assign trig_mode = !mode[`MODE_BIT_CONT] && (mode != `MODE_PDOWN);
  assign pin_shot  = convert_start && trig_mode && !cfg_wr;
  // Trigger ignored during recovery so settling is never cut short
  assign shot_go   = pin_shot && !power_down_q && (state_q != S_WAKE);

  // Separate averaging per channel; single sample when the multi bit is clear
  assign cur_avg   = adc_chan_q ? bavg : savg;
  assign avg_log   = cur_avg[`AVG_MULTI] ? cur_avg[`AVG_LOG_MSB:0] : 3'h0;
  assign avg_last  = (8'h01 << avg_log) - 8'h01;
  assign sample_ext = adc_chan_q ? {10'h000, adc_data[12:0]} :
                                   {{7{adc_data[15]}}, adc_data};
  assign acc_sum   = acc_q + sample_ext;
  assign avg_val   = acc_sum >>> avg_log;

  // Math engine kept off the sequencing path so conversions never wait for it
  pwr_calc u_calc (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (calc_start_q),
    .shunt   (shunt_q),
    .bus     (bus_q[15:`BUS_ALIGN]),
    .cal     (cal_q),
    .done    (calc_done),
    .current (calc_cur),
    .power   (calc_pwr)
  );

  // Sequencer and configuration
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q                <= `CFG_RESET;
      cal_q                <= `CAL_RESET;
      shunt_q              <= `RES_RESET;
      bus_q                <= `RES_RESET;
      shunt_new_q          <= `RES_RESET;
      state_q              <= S_SREQ;
      cnt_q                <= 8'h00;
      wake_q               <= 12'h000;
      acc_q                <= 23'h00_0000;
      calc_start_q         <= 1'b0;
      adc_start_q          <= 1'b0;
      adc_chan_q           <= 1'b0;
      adc_res_q            <= 2'h0;
      shunt_gain_setting_q <= 2'h0;
      bus_range_select_q   <= 1'b0;
      power_down_q         <= 1'b0;
    end else begin
      adc_start_q          <= 1'b0;
      calc_start_q         <= 1'b0;
      shunt_gain_setting_q <= cfg_q[`CFG_GAIN_MSB:`CFG_GAIN_LSB];
      bus_range_select_q   <= cfg_q[`CFG_BUS_RANGE];
      if (cal_wr) begin
        // Lowest bit is not stored
        cal_q <= {reg_wdata[15:1], 1'b0};
      end
      if (cfg_wr && reg_wdata[`CFG_SWRST]) begin
        // Software reset restores every register default
        cfg_q        <= `CFG_RESET;
        cal_q        <= `CAL_RESET;
        shunt_q      <= `RES_RESET;
        bus_q        <= `RES_RESET;
        power_down_q <= 1'b0;
        state_q      <= S_SREQ;
        cnt_q        <= 8'h00;
        acc_q        <= 23'h00_0000;
      end else if (cfg_wr) begin
        // Any mode write aborts the cycle in flight; active modes restart unless recovery is counting
        cfg_q  <= reg_wdata;
        cnt_q  <= 8'h00;
        acc_q  <= 23'h00_0000;
        if (wmode == `MODE_PDOWN) begin
          power_down_q <= 1'b1;
          state_q      <= S_IDLE;
        end else if (wmode == `MODE_ADC_OFF) begin
          state_q <= S_IDLE;
        end else if (power_down_q) begin
          power_down_q <= 1'b0;
          wake_q       <= 12'h000;
          state_q      <= S_WAKE;
        end else if (state_q == S_WAKE) begin
          // New mode during recovery keeps counting
          state_q <= S_WAKE;
        end else begin
          // Triggered modes start a shot even if already stored
          state_q <= wmode[`MODE_BIT_SHUNT] ? S_SREQ : S_BREQ;
        end
      end else if (shot_go) begin
        cnt_q   <= 8'h00;
        acc_q   <= 23'h00_0000;
        state_q <= mode[`MODE_BIT_SHUNT] ? S_SREQ : S_BREQ;
      end else begin
        case (state_q)
          S_IDLE: begin
            state_q <= S_IDLE;
          end
          S_WAKE: begin
            // Analog front end settles before the first valid sample
            if (wake_q == WAKE_LAST) begin
              state_q <= mode[`MODE_BIT_SHUNT] ? S_SREQ : S_BREQ;
            end else begin
              wake_q <= wake_q + 12'h001;
            end
          end
          S_SREQ: begin
            adc_start_q <= 1'b1;
            adc_chan_q  <= 1'b0;
            adc_res_q   <= savg[`AVG_RES_MSB:0];
            state_q     <= S_SWAIT;
          end
          S_SWAIT: begin
            if (adc_done) begin
              if (cnt_q == avg_last) begin
                shunt_new_q <= avg_val[15:0];
                cnt_q       <= 8'h00;
                acc_q       <= 23'h00_0000;
                if (mode[`MODE_BIT_BUS]) begin
                  state_q <= S_BREQ;
                end else begin
                  shunt_q      <= avg_val[15:0];
                  calc_start_q <= 1'b1;
                  state_q      <= mode[`MODE_BIT_CONT] ? S_SREQ : S_IDLE;
                end
              end else begin
                acc_q   <= acc_sum;
                cnt_q   <= cnt_q + 8'h01;
                state_q <= S_SREQ;
              end
            end
          end
          S_BREQ: begin
            adc_start_q <= 1'b1;
            adc_chan_q  <= 1'b1;
            adc_res_q   <= bavg[`AVG_RES_MSB:0];
            state_q     <= S_BWAIT;
          end
          S_BWAIT: begin
            if (adc_done) begin
              if (cnt_q == avg_last) begin
                cnt_q <= 8'h00;
                acc_q <= 23'h00_0000;
                // Shunt and bus of one cycle are committed together
                if (mode[`MODE_BIT_SHUNT]) begin
                  shunt_q <= shunt_new_q;
                end
                bus_q        <= {avg_val[12:0], 3'h0};
                calc_start_q <= 1'b1;
                // Continuous modes loop straight back without waiting on math
                if (mode[`MODE_BIT_CONT]) begin
                  state_q <= mode[`MODE_BIT_SHUNT] ? S_SREQ : S_BREQ;
                end else begin
                  state_q <= S_IDLE;
                end
              end else begin
                acc_q   <= acc_sum;
                cnt_q   <= cnt_q + 8'h01;
                state_q <= S_BREQ;
              end
            end
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Ready flag: setting wins over a clear in the same cycle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_q <= 1'b0;
    end else if (calc_done) begin
      ready_q <= 1'b1;
    end else if ((cfg_wr && (wr_active || reg_wdata[`CFG_SWRST])) || stat_rd || shot_go) begin
      ready_q <= 1'b0;
    end
  end

  // Computed results persist until the next calculation or a software reset replaces them
  reg [15:0] cur_q;
  reg [15:0] pwr_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_q <= `RES_RESET;
      pwr_q <= `RES_RESET;
    end else if (cfg_wr && reg_wdata[`CFG_SWRST]) begin
      cur_q <= `RES_RESET;
      pwr_q <= `RES_RESET;
    end else if (calc_done) begin
      cur_q <= calc_cur;
      pwr_q <= calc_pwr;
    end
  end

  // Read data registered one cycle after the read strobe
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_CONFIG:  reg_rdata_q <= cfg_q;
        `OFS_SHUNT:   reg_rdata_q <= shunt_q;
        `OFS_BUS:     reg_rdata_q <= bus_q;
        `OFS_POWER:   reg_rdata_q <= pwr_q;
        `OFS_CURRENT: reg_rdata_q <= cur_q;
        `OFS_CALIB:   reg_rdata_q <= cal_q;
        `OFS_STATUS:  reg_rdata_q <= {14'h0000, ready_q, (state_q != S_IDLE)};
        default:      reg_rdata_q <= 16'h0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== tb/adc_model.sv ====
// Converter stand-in answering each sample request after a set latency.
// Assumes one request in flight; samples alternate base and base+2 per channel.
`default_nettype none
module adc_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        adc_start_q,
  input  wire logic        adc_chan_q,
  input  wire logic [3:0]  lat,
  input  wire logic [15:0] shunt_base,
  input  wire logic [15:0] bus_base,
  output var  logic        adc_done,
  output var  logic [15:0] adc_data
);
  logic [3:0] cnt;
  logic       busy;
  logic       chan;
  logic       odd;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt      <= 4'h0;
      busy     <= 1'b0;
      chan     <= 1'b0;
      odd      <= 1'b0;
      adc_done <= 1'b0;
      adc_data <= 16'h0000;
    end else begin
      adc_done <= 1'b0;
      // Stale data flips every cycle so a read one cycle late sees a bad value
      adc_data <= ~adc_data;
      if (adc_start_q) begin
        busy <= 1'b1;
        cnt  <= lat;
        chan <= adc_chan_q;
        if (adc_chan_q != chan) begin
          odd <= 1'b0;
        end
      end else if (busy && cnt > 4'h1) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        busy     <= 1'b0;
        adc_done <= 1'b1;
        odd      <= ~odd;
        adc_data <= (chan ? bus_base : shunt_base) + {odd, 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/pwr_mon_ctrl_sva.sv ====
// Port checker for the conversion control block.
// Assumes binding to pwr_mon_ctrl; sees only its ports.
`default_nettype none
module pwr_mon_ctrl_sva (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic        convert_start,
  input wire logic        adc_start_q,
  input wire logic        adc_chan_q,
  input wire logic [1:0]  shunt_gain_setting_q,
  input wire logic        bus_range_select_q,
  input wire logic        power_down_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire         cfg_wr;
  logic [12:0] since_pd_q;
  logic        off_q;
  assign cfg_wr = reg_wr && reg_addr == 8'h00;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      since_pd_q <= 13'h1fff;
      off_q      <= 1'b0;
    end else begin
      // Saturates so a long run never wraps into a false window
      if (cfg_wr && power_down_q && reg_wdata[2:0] != 3'h0 && !reg_wdata[15]) begin
        since_pd_q <= 13'h0000;
      end else if (since_pd_q != 13'h1fff) begin
        since_pd_q <= since_pd_q + 13'h0001;
      end
      if (cfg_wr) begin
        off_q <= reg_wdata[2:0] == 3'h4 && !reg_wdata[15];
      end
    end
  end
  sequence go_shunt;
    cfg_wr && !power_down_q && reg_wdata[0];
  endsequence
  sequence go_bus;
    cfg_wr && !power_down_q && !reg_wdata[15] && reg_wdata[1:0] == 2'h2;
  endsequence
  sequence shunt_req;
    adc_start_q && !adc_chan_q;
  endsequence
  sequence bus_req;
    adc_start_q && adc_chan_q;
  endsequence
  // A mode write or trigger may abort and restart right after a request
  a_start_pulse: assert property (adc_start_q && !cfg_wr && !convert_start |=>
      !adc_start_q [*2])
    else $error("sample request too long");
  a_shunt_first: assert property (go_shunt |-> ##[1:3] shunt_req)
    else $error("shunt sample did not start first");
  a_bus_only: assert property (go_bus |-> ##[1:3] bus_req)
    else $error("bus only mode did not start");
  a_pd_enter: assert property (cfg_wr && reg_wdata[2:0] == 3'h0 && !reg_wdata[15]
      |=> power_down_q)
    else $error("power down not entered");
  a_pd_quiet: assert property (power_down_q |-> !adc_start_q)
    else $error("sample in power down");
  a_pd_recovery: assert property (adc_start_q |-> since_pd_q > 13'h0f96)
    else $error("recovery interval cut short");
  a_off_halt: assert property (off_q && $past(off_q) |-> !adc_start_q)
    else $error("sample while converter off");
  a_range_copy: assert property (cfg_wr && !reg_wdata[15] |-> ##2
      shunt_gain_setting_q == $past(reg_wdata[12:11], 2)
      && bus_range_select_q == $past(reg_wdata[13], 2))
    else $error("gain or range not taken");
  a_soft_reset: assert property (cfg_wr && reg_wdata[15] |->
      ##[1:2] shunt_gain_setting_q == 2'h3 && bus_range_select_q)
    else $error("software reset missed defaults");
endmodule
`default_nettype wire

// ==== tb/power_monitor_conversion_control_tb_top.sv ====
// Register level bench for the conversion control block.
// Assumes adc_model on the converter side and the strobe register port.
`default_nettype none
module power_monitor_conversion_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, convert_start = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata_q, adc_data, d, cur;
  logic        adc_start_q, adc_chan_q, adc_done, bus_range_select_q, power_down_q;
  logic [1:0]  adc_res_q, shunt_gain_setting_q;
  logic [3:0]  lat = 4'h3;
  logic [2:0]  mv;
  int          miscompares = 0, checks = 0, n_sh = 0, n_bu = 0, cyc;
  localparam logic [15:0] SB = 16'h0100, BB = 16'h0fa0;
  localparam logic [15:0] CAL = 16'h5000; // 1e-4 A weight, 20 mOhm shunt
  always #5 clk = ~clk;
  pwr_mon_ctrl DUT (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .convert_start(convert_start), .adc_start_q(adc_start_q), .adc_chan_q(adc_chan_q),
    .adc_res_q(adc_res_q), .adc_done(adc_done), .adc_data(adc_data),
    .shunt_gain_setting_q(shunt_gain_setting_q), .bus_range_select_q(bus_range_select_q),
    .power_down_q(power_down_q));
  adc_model adc (.clk(clk), .reset_n(reset_n), .adc_start_q(adc_start_q),
    .adc_chan_q(adc_chan_q), .lat(lat), .shunt_base(SB), .bus_base(BB),
    .adc_done(adc_done), .adc_data(adc_data));
  always @(posedge clk) begin
    if (adc_start_q === 1'b1) begin
      if (adc_chan_q) n_bu++;
      else n_sh++;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata_q;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [15:0] e);
    rd(a);
    chk(n, e, d);
  endtask
  task automatic wait_ready;
    d = 16'h0000;
    for (int i = 0; i < 600 && d[1] !== 1'b1; i++) begin
      repeat (10) @(negedge clk);
      rd(8'h06);
    end
    chk("ready", 16'h0002, d & 16'h0002);
  endtask
  task automatic pulse;
    @(negedge clk) convert_start = 1'b1;
    @(negedge clk) convert_start = 1'b0;
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    rchk("config", 8'h00, 16'h399f);
    rchk("calib", 8'h05, 16'h0000);
    wr(8'h05, CAL);
    wr(8'h00, 16'h0007);
    wait_ready();
    wait_ready();
    rchk("shunt", 8'h01, SB);
    rchk("bus", 8'h02, {BB[12:0], 3'b000});
    cur = 16'((32'(SB) * 32'(CAL)) >> 12);
    rchk("current", 8'h04, cur);
    wr(8'h03, 16'h1234);
    rchk("power", 8'h03, 16'((32'(cur) * 32'(BB)) / 5000));
    $display("test continuous done");
    wr(8'h00, 16'h0004);
    n_sh = 0;
    n_bu = 0;
    repeat (100) @(negedge clk);
    pulse();
    repeat (100) @(negedge clk);
    chk("off starts", 16'h0000, 16'(n_sh + n_bu));
    $display("test converter off done");
    // Gain and range follow the mode so gain settings 1 to 3 and both ranges are seen
    for (int m = 1; m < 4; m++) begin
      mv = 3'(m);
      lat = 4'(2 * m - 1);
      n_sh = 0;
      n_bu = 0;
      wr(8'h00, {2'b00, mv[0], mv[1:0], 4'b1001, 4'b1010, mv});
      wait_ready();
      chk("shunt starts", mv[0] ? 16'h0004 : 16'h0000, 16'(n_sh));
      chk("bus starts", mv[1] ? 16'h0002 : 16'h0000, 16'(n_bu));
      rchk("shunt avg", 8'h01, SB + 16'h0001);
      rchk("bus avg", 8'h02, 16'((mv[1] ? BB + 16'h0001 : BB) << 3));
      chk("gain", {14'h0000, mv[1:0]}, {14'h0000, shunt_gain_setting_q});
      chk("range", {15'h0000, mv[0]}, {15'h0000, bus_range_select_q});
      chk("res", mv[1] ? 16'h0001 : 16'h0002, {14'h0000, adc_res_q});
      n_sh = 0;
      n_bu = 0;
      repeat (100) @(negedge clk);
      chk("idle starts", 16'h0000, 16'(n_sh + n_bu));
      rchk("status clr", 8'h06, 16'h0000);
    end
    $display("test triggered modes done");
    wr(8'h00, 16'h0553);
    repeat (300) @(negedge clk);
    rchk("held ready", 8'h06, 16'h0002);
    pulse();
    repeat (300) @(negedge clk);
    pulse();
    rchk("trig clr", 8'h06, 16'h0001);
    wait_ready();
    $display("test trigger pin done");
    wr(8'h00, 16'h0000);
    chk("pd", 16'h0001, {15'h0000, power_down_q});
    n_sh = 0;
    wr(8'h00, 16'h0003);
    for (cyc = 0; cyc < 5000 && n_sh == 0; cyc++) @(negedge clk);
    chk("recovery", 16'h0001, {15'h0000, cyc > 3990 && cyc < 4010});
    wait_ready();
    wr(8'h05, 16'h0000);
    wr(8'h00, 16'h0003);
    wait_ready();
    rchk("current zero", 8'h04, 16'h0000);
    rchk("power zero", 8'h03, 16'h0000);
    wr(8'h00, 16'h8000);
    rchk("soft reset", 8'h00, 16'h399f);
    $display("test power down done");
    give_verdict();
  end
endmodule
bind pwr_mon_ctrl pwr_mon_ctrl_sva chk_i (.clk(clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .convert_start(convert_start), .adc_start_q(adc_start_q),
  .adc_chan_q(adc_chan_q), .shunt_gain_setting_q(shunt_gain_setting_q),
  .bus_range_select_q(bus_range_select_q), .power_down_q(power_down_q));
`default_nettype wire
